// file: design/link_status_map.svh
`ifndef LINK_STATUS_MAP_SVH
`define LINK_STATUS_MAP_SVH

// Configuration offsets (byte addresses)
`define LINK_CONTROL_OFFSET   12'h0A0
`define LINK_STATUS_OFFSET    12'h0A2
`define SLOT_CAP_OFFSET       12'h0A4

// Link control field positions
`define LCTL_ASPM_LSB         0
`define LCTL_RSVD_BIT         2
`define LCTL_BOUNDARY_BIT     3

// Link status field positions
`define LSTS_RATE_LSB         0
`define LSTS_WIDTH_LSB        4
`define LSTS_UNDEFINED_BIT    10
`define LSTS_TRAIN_BIT        11
`define LSTS_REFCLK_BIT       12
`define LSTS_LINK_UP_BIT      13

// Fixed and reset values
`define LCTL_RESET            16'h0000
`define LSTS_RATE_VALUE       4'h1
`define LSTS_WIDTH_VALUE      6'h01
`define LSTS_REFCLK_VALUE     1'h1
`define SLOT_CAP_RESET        32'h0000_0060

// Input synchroniser depth
`define SYNC_STAGES           2

`endif

// file: design/link_status_pkg.sv
package link_status_pkg;

  typedef enum logic [1:0] {
    ASPM_OFF      = 2'b00,
    ASPM_L0S      = 2'b01,
    ASPM_RESERVED = 2'b10,
    ASPM_L0S_L1   = 2'b11
  } aspm_mode_e;

endpackage

// file: design/level_sync.sv
`timescale 1ns/100ps

module level_sync #(
  parameter int WIDTH  = 2,
  parameter int STAGES = 2
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  if (STAGES < 2) begin : g_check
    $error("level_sync needs at least two stages");
  end

  for (genvar i = 0; i < WIDTH; i++) begin : g_bit
    logic [STAGES-1:0] chain;
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        chain <= '0;
      end else begin
        chain <= {chain[STAGES-2:0], async_in[i]};
      end
    end
    assign sync_out[i] = chain[STAGES-1];
  end

endmodule // level_sync

// file: design/downstream_link_status_regs.sv
// Overview of operation
// - Completion boundary bit 3 of link control is hardwired zero, meaning 64 bytes.
// - Link control bit 2 is reserved and always reads zero.
// - Writable field 1:0 selects power management: off, L0s, reserved, L0s and L1.
// - Link status bits 15 and 14 are reserved and read zero.
// - With reporting capable, bit 13 reads one while link layer is active, lagging dl_active_in by SYNC_STAGES plus one cycles.
// - Without reporting capability, bit 13 reads zero whatever the link does.
// - Bit 12 is read-only one, reporting a common 100 MHz reference clock.
// - Bit 11 is hardware-updated and clears when training leaves Configuration/Recovery.
// - Link status bit 10 is undefined; software must not rely on it.
// - Bits 9:4 read fixed 000001b, a single-lane link.
// - Bits 3:0 read fixed 0001b, a 2.5 Gb/s link.
// - Link status is read-only; configuration writes to it have no effect.
// - Slot capabilities at A4h read 0000 0060h after reset.
`timescale 1ns/100ps
`include "link_status_map.svh"

module downstream_link_status_regs
  import link_status_pkg::*;
#(
  parameter int SYNC_STAGES = `SYNC_STAGES
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rstn,
  // Configuration access
  input  wire logic        cfg_req,
  input  wire logic        cfg_wr,
  input  wire logic [11:0] cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_ack,
  // Link state indications
  input  wire logic        link_up_report_capable,
  input  wire logic        dl_active_in,
  input  wire logic        ltssm_cfg_recovery_in,
  // Power management enables
  output logic             l0s_entry_enable,
  output logic             l1_entry_enable
);

  if (SYNC_STAGES < 2) begin : g_check
    $error("SYNC_STAGES must be at least two");
  end

  // Reset release
  logic [1:0]  rst_pipe;
  logic        rst_n;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'h1};
    end
  end
  assign rst_n = rst_pipe[1];

  // Link state synchronisers
  logic [1:0]  link_sync;
  logic        dl_active_sync;
  logic        training_sync;

  level_sync #(
    .WIDTH  (2),
    .STAGES (SYNC_STAGES)
  ) u_link_sync (
    .clk      (sys_clk),
    .rst_n    (rst_n),
    .async_in ({ltssm_cfg_recovery_in, dl_active_in}),
    .sync_out (link_sync)
  );
  assign dl_active_sync = link_sync[0];
  assign training_sync  = link_sync[1];

  // Status state
  logic        link_layer_up_flag;
  logic        training_in_progress;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_layer_up_flag   <= 1'h0;
      training_in_progress <= 1'h0;
    end else begin
      link_layer_up_flag   <= link_up_report_capable & dl_active_sync;
      training_in_progress <= training_sync;
    end
  end

  // Link control
  aspm_mode_e  active_pm_entry_enable;
  logic [15:0] downstream_link_control;
  logic        completion_boundary_sel;
  logic        ctl_hit;
  logic        cap_hit;
  logic        ctl_wr;
  aspm_mode_e  next_aspm;

  // Completions are never split, so the boundary stays at 64 bytes
  assign completion_boundary_sel = 1'h0;
  assign ctl_hit = cfg_addr[11:2] == 10'(`LINK_CONTROL_OFFSET >> 2);
  assign cap_hit = cfg_addr[11:2] == 10'(`SLOT_CAP_OFFSET >> 2);
  assign ctl_wr  = cfg_req & cfg_wr & ctl_hit & cfg_be[0];
  assign next_aspm = ctl_wr ? aspm_mode_e'(cfg_wdata[`LCTL_ASPM_LSB +: 2])
                            : active_pm_entry_enable;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      active_pm_entry_enable <= ASPM_OFF;
    end else begin
      active_pm_entry_enable <= next_aspm;
    end
  end

  always_comb begin
    downstream_link_control = `LCTL_RESET;
    downstream_link_control[`LCTL_ASPM_LSB +: 2] = active_pm_entry_enable;
    downstream_link_control[`LCTL_RSVD_BIT]      = 1'h0;
    downstream_link_control[`LCTL_BOUNDARY_BIT]  = completion_boundary_sel;
  end

  // Power management enables follow the field; the reserved code enables nothing
  logic        next_l0s;
  logic        next_l1;

  assign next_l0s = next_aspm == ASPM_L0S || next_aspm == ASPM_L0S_L1;
  assign next_l1  = next_aspm == ASPM_L0S_L1;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      l0s_entry_enable <= 1'h0;
      l1_entry_enable  <= 1'h0;
    end else begin
      l0s_entry_enable <= next_l0s;
      l1_entry_enable  <= next_l1;
    end
  end

  // Link status, no write path exists
  logic [15:0] downstream_link_status;

  always_comb begin
    downstream_link_status = 16'h0000;
    downstream_link_status[`LSTS_RATE_LSB +: 4]  = `LSTS_RATE_VALUE;
    downstream_link_status[`LSTS_WIDTH_LSB +: 6] = `LSTS_WIDTH_VALUE;
    downstream_link_status[`LSTS_UNDEFINED_BIT]  = 1'h0;
    downstream_link_status[`LSTS_TRAIN_BIT]      = training_in_progress;
    downstream_link_status[`LSTS_REFCLK_BIT]     = `LSTS_REFCLK_VALUE;
    downstream_link_status[`LSTS_LINK_UP_BIT]    = link_layer_up_flag;
  end

  // Slot capabilities, held at its reset value
  logic [31:0] downstream_slot_capabilities;
  assign downstream_slot_capabilities = `SLOT_CAP_RESET;

  // Read selection
  logic [31:0] read_word;
  logic [31:0] next_rdata;

  assign read_word  = ctl_hit ? {downstream_link_status, downstream_link_control}
                    : cap_hit ? downstream_slot_capabilities
                    : 32'h0000_0000;
  assign next_rdata = (cfg_req & ~cfg_wr) ? read_word : 32'h0000_0000;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_rdata <= 32'h0000_0000;
      cfg_ack   <= 1'h0;
    end else begin
      cfg_rdata <= next_rdata;
      cfg_ack   <= cfg_req;
    end
  end

endmodule // downstream_link_status_regs

// file: test/downstream_link_status_assertions.sv
`timescale 1ns/100ps

module downstream_link_status_assertions (
  // Clock, reset and access
  input wire logic        sys_clk,
  input wire logic        rstn,
  input wire logic        cfg_req,
  input wire logic        cfg_wr,
  input wire logic [11:0] cfg_addr,
  input wire logic [3:0]  cfg_be,
  input wire logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata,
  input wire logic        cfg_ack,
  // Link and power management
  input wire logic        link_up_report_capable,
  input wire logic        dl_active_in,
  input wire logic        ltssm_cfg_recovery_in,
  input wire logic        l0s_entry_enable,
  input wire logic        l1_entry_enable
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);
  sequence rd_ctl;
    cfg_req && !cfg_wr && cfg_addr[11:2] == 10'h028;
  endsequence
  sequence wr_ctl;
    cfg_req && cfg_wr && cfg_be[0] && cfg_addr[11:2] == 10'h028;
  endsequence
  a_ack_pulse: assert property (cfg_req |=> cfg_ack) else $error("missing ack");
  a_ack_idle: assert property (!cfg_req |=> !cfg_ack) else $error("stray ack");
  a_ctl_fixed: assert property (rd_ctl |=> cfg_rdata[15:2] == 14'h0)
    else $error("control fixed bits");
  a_sts_fixed: assert property (rd_ctl |=> cfg_rdata[31:30] == 2'h0 && cfg_rdata[28]
    && cfg_rdata[25:16] == 10'h011) else $error("status fixed bits");
  a_slot_cap: assert property (cfg_req && !cfg_wr && cfg_addr[11:2] == 10'h029
    |=> cfg_rdata == 32'h0000_0060) else $error("slot capabilities");
  a_link_up: assert property ((link_up_report_capable && $stable(dl_active_in))[*6]
    ##0 rd_ctl |=> cfg_rdata[29] == $past(dl_active_in)) else $error("link active");
  a_link_gated: assert property ((!link_up_report_capable)[*2] ##0 rd_ctl
    |=> !cfg_rdata[29]) else $error("link active gated");
  a_train_bit: assert property ($stable(ltssm_cfg_recovery_in)[*6] ##0 rd_ctl
    |=> cfg_rdata[27] == $past(ltssm_cfg_recovery_in)) else $error("training bit");
  a_pm_enables: assert property (wr_ctl |=> l0s_entry_enable == $past(cfg_wdata[0])
    && l1_entry_enable == ($past(cfg_wdata[1:0]) == 2'h3)) else $error("pm enables");
endmodule // downstream_link_status_assertions

// file: test/link_partner_model.sv
`timescale 1ns/100ps

module link_partner_model (
  // Bench control
  input  wire logic       clk,
  input  wire logic       start,
  input  wire logic [4:0] len,
  // Link indications
  output logic            training,
  output logic            link_up
);
  logic [4:0] cnt;
  initial begin
    cnt = 5'h0;
    training = 1'b0;
    link_up = 1'b0;
  end
  // Training lasts len cycles, then the link layer goes active
  always @(negedge clk) begin
    if (start) begin
      cnt <= len;
      training <= 1'b1;
      link_up <= 1'b0;
    end else if (cnt != 5'h0) begin
      cnt <= cnt - 5'h1;
      training <= cnt != 5'h1;
      link_up <= cnt == 5'h1;
    end
  end
endmodule // link_partner_model

// file: test/downstream_link_status_regs_test.sv
`timescale 1ns/100ps

module downstream_link_status_regs_test;
  logic sys_clk = 1'b0, rstn = 1'b0, cfg_req = 1'b0, cfg_wr = 1'b0, start = 1'b0;
  logic link_up_report_capable = 1'b0;
  logic [11:0] cfg_addr = 12'h0;
  logic [3:0] cfg_be = 4'h0;
  logic [4:0] len = 5'h0;
  logic [31:0] cfg_wdata = 32'h0, cfg_rdata, r;
  logic cfg_ack, dl_active_in, ltssm_cfg_recovery_in, l0s_entry_enable, l1_entry_enable;
  int err_count = 0, checks = 0;

  always #2 sys_clk = ~sys_clk;

  downstream_link_status_regs dut (.sys_clk, .rstn, .cfg_req, .cfg_wr, .cfg_addr, .cfg_be,
    .cfg_wdata, .cfg_rdata, .cfg_ack, .link_up_report_capable, .dl_active_in,
    .ltssm_cfg_recovery_in, .l0s_entry_enable, .l1_entry_enable);
  link_partner_model partner (.clk(sys_clk), .start, .len,
    .training(ltssm_cfg_recovery_in), .link_up(dl_active_in));

  task automatic end_sim;
    if (err_count == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic acc(input logic w, input logic [11:0] a, input logic [3:0] b,
                     input logic [31:0] d);
    @(negedge sys_clk);
    {cfg_req, cfg_wr, cfg_addr, cfg_be, cfg_wdata} = {1'b1, w, a, b, d};
    @(negedge sys_clk);
    r = cfg_rdata;
    chk("ack", {31'h0, cfg_ack}, 32'h1);
    cfg_req = 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    acc(1'b0, a, 4'h0, 32'h0);
    chk("rdata", r, e);
  endtask
  task automatic train(input logic [4:0] n);
    @(negedge sys_clk);
    start <= 1'b1;
    len <= n;
    @(negedge sys_clk);
    start <= 1'b0;
    repeat (6) @(negedge sys_clk);
  endtask

  initial begin
    repeat (12) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd(12'h0A0, 32'h1011_0000);
    rd(12'h0A8, 32'h0);
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, 12'h0A0, 4'hF, {30'h3FFF_FFFF, i[1:0]});
      rd(12'h0A0, {16'h1011, 14'h0, i[1:0]});
      chk("l0s", {31'h0, l0s_entry_enable}, {31'h0, i[0]});
      chk("l1", {31'h0, l1_entry_enable}, {31'h0, i == 3});
    end
    acc(1'b1, 12'h0A0, 4'hE, 32'h0);
    acc(1'b1, 12'h0A4, 4'hF, 32'h0);
    rd(12'h0A0, 32'h1011_0003);
    rd(12'h0A4, 32'h0000_0060);
    train(5'h14);
    rd(12'h0A0, 32'h1811_0003);
    repeat (30) @(negedge sys_clk);
    rd(12'h0A0, 32'h1011_0003);
    link_up_report_capable = 1'b1;
    repeat (4) @(negedge sys_clk);
    rd(12'h0A0, 32'h3011_0003);
    train(5'h14);
    rd(12'h0A0, 32'h1811_0003);
    train(5'h3);
    rd(12'h0A0, 32'h3011_0003);
    rstn = 1'b0;
    repeat (3) @(negedge sys_clk);
    rstn = 1'b1;
    repeat (6) @(negedge sys_clk);
    rd(12'h0A0, 32'h3011_0000);
    chk("l0s", {31'h0, l0s_entry_enable}, 32'h0);
    chk("l1", {31'h0, l1_entry_enable}, 32'h0);
    rd(12'h0A4, 32'h0000_0060);
    end_sim;
  end
  initial begin
    #4000;
    err_count++;
    end_sim;
  end
endmodule // downstream_link_status_regs_test

bind downstream_link_status_regs downstream_link_status_assertions u_chk (.sys_clk, .rstn,
  .cfg_req, .cfg_wr, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_ack,
  .link_up_report_capable, .dl_active_in, .ltssm_cfg_recovery_in, .l0s_entry_enable,
  .l1_entry_enable);
